// ### hdl/rfsr_top.sv
/*
 * rfsr_top: rail 1 status bank (summary byte, summary word, output-voltage
 * status), clear-faults handling, monitor watchdog and rail ready tracking.
 * Assumes events come from rail logic on clk; rail_en_pin is an external pin.
 * Register access is by command code on the host command port.
 */
// How it works
// - byte bit 7 shows memory busy live
// - byte bit 6 live rail-off indicator
// - byte bit 5 latches output overvoltage trip
// - byte bit 4 latches output overcurrent trip
// - byte bit 3 latches input undervoltage fault
// - byte bit 2 latches temperature warning or fault
// - byte bit 1 latches any comm fault
// - byte bit 0 flags input overcurrent warning
// - clear-faults command 03h resets latched bits
// - word bit 15 latches output voltage events
// - word bit 14 latches current/power events
// - word bit 13 latches input side events
// - word bits 12,10 latch supply faults
// - vendor mode: ready at boot voltage
// - other mode: ready after threshold and delay
// - other mode: drop below off threshold, fault
// - watchdog overflow resets monitor, sets bit 8
// - word low byte equals summary byte
// - output_voltage_summary bit 7 latches overvoltage trip
// - output_voltage_summary bit 4 latches undervoltage trip
// - output_voltage_summary bit 3 latches code limit violation
// - sense float shuts rail, latches bit 1
`timescale 1ns/100ps

module rfsr_top (
    input wire logic clk, // 40 MHz system clock
    input wire logic reset_n, // async reset, active low
    input wire logic cmd_valid, // host command strobe
    input wire logic [7:0] cmd_code, // command code
    output logic rd_valid, // read data valid pulse
    output logic [15:0] rd_data, // read data
    output logic rd_unsup, // unsupported code pulse
    input wire rfsr_pkg::rfsr_evt_s evt, // protection events
    input wire logic nvm_busy_flag, // nonvolatile store busy
    input wire logic rail_en_pin, // rail enable pin
    input wire logic [rfsr_pkg::VID_W-1:0] vid_code, // requested voltage code
    input wire logic [rfsr_pkg::CODE_W-1:0] code_max, // configured maximum code
    input wire logic [rfsr_pkg::CODE_W-1:0] code_min, // configured minimum code
    input wire logic [rfsr_pkg::VID_W-1:0] output_voltage_summary_code, // sensed output code
    input wire logic boot_reached, // output at boot voltage
    input wire rfsr_pkg::rfsr_rdy_cfg_s rdy_cfg, // ready configuration
    input wire logic mon_start, // monitor calculation start
    input wire logic mon_done, // monitor calculation done
    output logic mon_sm_reset, // monitor state machine reset pulse
    output logic rail_shutdown, // rail forced off by line float
    output logic regulator_ready_output // rail ready
);

    logic rst_meta;
    logic rst_n;
    logic en_meta;
    logic en_sync;
    logic clear_faults;
    logic rail_off;
    logic rail_fault;
    logic limit_hit;
    logic wdog_ovf;
    logic mon_busy_reg;
    logic [10:0] wdog_reg;
    logic [rfsr_pkg::FL_COUNT-1:0] set_vec;
    logic [rfsr_pkg::FL_COUNT-1:0] flags;
    logic [7:0] summary_byte;
    logic [15:0] summary_word;
    logic [7:0] output_voltage_summary_status;
    logic rdy;

    // ==========================================================
    // reset release and pin synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end else begin
            en_meta <= rail_en_pin;
            en_sync <= en_meta;
        end
    end

    // ==========================================================
    // live conditions
    assign clear_faults = cmd_valid && (cmd_code == rfsr_pkg::CMD_CLEAR_FAULTS);
    assign rail_off = evt.prot_off | rail_shutdown | !en_sync | (vid_code == '0);
    assign rail_fault = evt.ovp_trip | evt.ocp_trip | evt.uvp_trip | evt.line_float
        | evt.prot_off | rail_shutdown;
    assign limit_hit = (rfsr_pkg::CODE_W'(vid_code) > code_max)
        | (rfsr_pkg::CODE_W'(vid_code) < code_min);
    assign wdog_ovf = mon_busy_reg && (wdog_reg == 11'(rfsr_pkg::WDOG_LIMIT_CYC - 1));

    // ==========================================================
    // event to flag mapping
    always_comb begin
        set_vec = '0;
        set_vec[rfsr_pkg::FL_OV] = evt.ovp_trip;
        set_vec[rfsr_pkg::FL_OC] = evt.ocp_trip;
        set_vec[rfsr_pkg::FL_VIN_UV] = evt.input_undervoltage_flag;
        set_vec[rfsr_pkg::FL_TEMP] = evt.ot_warn | evt.ot_fault;
        set_vec[rfsr_pkg::FL_COMM] = evt.comm_fault;
        set_vec[rfsr_pkg::FL_IIN_WARN] = evt.input_overcurrent_warning;
        set_vec[rfsr_pkg::FL_OUTPUT_VOLTAGE_SUMMARY_SUM] = evt.ovp_trip | evt.uvp_trip
            | evt.output_voltage_summary_ov_warn | evt.output_voltage_summary_uv_warn;
        set_vec[rfsr_pkg::FL_IOUT_SUM] = evt.ocp_trip | evt.iout_warn
            | evt.pout_fault | evt.pout_warn;
        set_vec[rfsr_pkg::FL_INPUT_SUM] = evt.input_undervoltage_flag | evt.vin_ov_fault
            | evt.iin_oc_fault | evt.input_overcurrent_warning | evt.pin_warn;
        set_vec[rfsr_pkg::FL_SYS_ANA] = evt.sys_ana_fault;
        set_vec[rfsr_pkg::FL_SYS_DIG] = evt.sys_dig_fault;
        set_vec[rfsr_pkg::FL_WDOG] = wdog_ovf;
        set_vec[rfsr_pkg::FL_UV] = evt.uvp_trip;
        set_vec[rfsr_pkg::FL_LIMIT] = limit_hit;
        set_vec[rfsr_pkg::FL_FLOAT] = evt.line_float;
    end

    rfsr_sticky #(
        .N(rfsr_pkg::FL_COUNT)
    ) u_sticky (
        .clk(clk),
        .rst_n(rst_n),
        .set(set_vec),
        .clear(clear_faults),
        .flags(flags)
    );

    rfsr_ready u_ready (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(rdy_cfg),
        .output_voltage_summary_code(output_voltage_summary_code),
        .boot_reached(boot_reached),
        .enabled(!rail_off),
        .fault(rail_fault),
        .ready(rdy)
    );

    // ==========================================================
    // line float shutdown, held until clear-faults
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rail_shutdown <= 1'b0;
        end else begin
            rail_shutdown <= evt.line_float | (rail_shutdown & ~clear_faults);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regulator_ready_output <= 1'b0;
        end else begin
            regulator_ready_output <= rdy;
        end
    end

    // ==========================================================
    // monitor calculation watchdog
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_busy_reg <= 1'b0;
            wdog_reg <= '0;
        end else if (wdog_ovf) begin
            mon_busy_reg <= 1'b0;
            wdog_reg <= '0;
        end else if (mon_start) begin
            mon_busy_reg <= 1'b1;
            wdog_reg <= '0;
        end else if (mon_done) begin
            mon_busy_reg <= 1'b0;
            wdog_reg <= '0;
        end else if (mon_busy_reg) begin
            wdog_reg <= wdog_reg + 11'd1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_sm_reset <= 1'b0;
        end else begin
            mon_sm_reset <= wdog_ovf;
        end
    end

    // ==========================================================
    // register images
    always_comb begin
        summary_byte = '0;
        summary_byte[rfsr_pkg::SB_NVM_BUSY] = nvm_busy_flag;
        summary_byte[rfsr_pkg::SB_RAIL_OFF] = rail_off;
        summary_byte[rfsr_pkg::SB_OV] = flags[rfsr_pkg::FL_OV];
        summary_byte[rfsr_pkg::SB_OC] = flags[rfsr_pkg::FL_OC];
        summary_byte[rfsr_pkg::SB_VIN_UV] = flags[rfsr_pkg::FL_VIN_UV];
        summary_byte[rfsr_pkg::SB_TEMP] = flags[rfsr_pkg::FL_TEMP];
        summary_byte[rfsr_pkg::SB_COMM] = flags[rfsr_pkg::FL_COMM];
        summary_byte[rfsr_pkg::SB_IIN_WARN] = flags[rfsr_pkg::FL_IIN_WARN];
        summary_word = {8'h00, summary_byte};
        summary_word[rfsr_pkg::SW_OUTPUT_VOLTAGE_SUMMARY] = flags[rfsr_pkg::FL_OUTPUT_VOLTAGE_SUMMARY_SUM];
        summary_word[rfsr_pkg::SW_OUTPUT_CURRENT_POWER_SUMMARY] = flags[rfsr_pkg::FL_IOUT_SUM];
        summary_word[rfsr_pkg::SW_INPUT] = flags[rfsr_pkg::FL_INPUT_SUM];
        summary_word[rfsr_pkg::SW_SYS_ANA] = flags[rfsr_pkg::FL_SYS_ANA];
        summary_word[rfsr_pkg::SW_READY] = regulator_ready_output;
        summary_word[rfsr_pkg::SW_SYS_DIG] = flags[rfsr_pkg::FL_SYS_DIG];
        summary_word[rfsr_pkg::SW_WDOG] = flags[rfsr_pkg::FL_WDOG];
        output_voltage_summary_status = '0;
        output_voltage_summary_status[rfsr_pkg::VS_OV] = flags[rfsr_pkg::FL_OV];
        output_voltage_summary_status[rfsr_pkg::VS_UV] = flags[rfsr_pkg::FL_UV];
        output_voltage_summary_status[rfsr_pkg::VS_LIMIT] = flags[rfsr_pkg::FL_LIMIT];
        output_voltage_summary_status[rfsr_pkg::VS_FLOAT] = flags[rfsr_pkg::FL_FLOAT];
    end

    // ==========================================================
    // command port answer, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_unsup <= 1'b0;
            rd_data <= rfsr_pkg::RD_DATA_RST;
        end else begin
            rd_valid <= 1'b0;
            rd_unsup <= 1'b0;
            if (cmd_valid) begin
                case (cmd_code)
                    rfsr_pkg::OFF_SUMMARY_BYTE: begin
                        rd_valid <= 1'b1;
                        rd_data <= {8'h00, summary_byte};
                    end
                    rfsr_pkg::OFF_SUMMARY_WORD: begin
                        rd_valid <= 1'b1;
                        rd_data <= summary_word;
                    end
                    rfsr_pkg::OFF_OUTPUT_VOLTAGE_SUMMARY_STATUS: begin
                        rd_valid <= 1'b1;
                        rd_data <= {8'h00, output_voltage_summary_status};
                    end
                    rfsr_pkg::CMD_CLEAR_FAULTS: begin
                        rd_data <= rd_data;
                    end
                    default: begin
                        rd_unsup <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    ov_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.ovp_trip |=> flags[rfsr_pkg::FL_OV])
        else $error("overvoltage flag not latched");

    clear_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clear_faults && set_vec == '0) |=> (flags == '0))
        else $error("clear-faults left a flag set");

    set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        (clear_faults && evt.ocp_trip) |=> flags[rfsr_pkg::FL_OC])
        else $error("event lost during clear");

    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (flags[rfsr_pkg::FL_OUTPUT_VOLTAGE_SUMMARY_SUM] && !clear_faults) |=> flags[rfsr_pkg::FL_OUTPUT_VOLTAGE_SUMMARY_SUM])
        else $error("latched flag dropped without clear");

    rail_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_code == rfsr_pkg::OFF_SUMMARY_BYTE && vid_code == '0)
        |=> rd_data[rfsr_pkg::SB_RAIL_OFF])
        else $error("rail-off bit not reported");

    word_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_code == rfsr_pkg::OFF_SUMMARY_WORD)
        |=> (rd_valid && rd_data[7:0] == $past(summary_byte)))
        else $error("word low byte differs from summary byte");

    wdog_ovf_a: assert property (@(posedge clk) disable iff (!rst_n)
        wdog_ovf |=> (mon_sm_reset && !mon_busy_reg && wdog_reg == '0
        && flags[rfsr_pkg::FL_WDOG]))
        else $error("watchdog overflow not handled");

    float_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        evt.line_float |=> (rail_shutdown && flags[rfsr_pkg::FL_FLOAT]) ##1 rail_off)
        else $error("line float did not shut the rail");

    limit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rfsr_pkg::CODE_W'(vid_code) > code_max) |=> flags[rfsr_pkg::FL_LIMIT])
        else $error("code limit not latched");

    ready_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rdy_cfg.pol_mode && rail_fault) |=> ##1 !regulator_ready_output)
        else $error("ready held through a fault");

    ready_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!rdy_cfg.pol_mode && rail_off) |=> ##1 !regulator_ready_output)
        else $error("ready held with rail off");

    busy_live_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_code == rfsr_pkg::OFF_SUMMARY_BYTE)
        |=> (rd_data[rfsr_pkg::SB_NVM_BUSY] == $past(nvm_busy_flag)))
        else $error("busy bit not live");

endmodule // rfsr_top

// ### hdl/rfsr_pkg.sv
/*
 * rfsr_pkg: constants, types and register layout for the rail 1 status bank.
 * Assumes a single 40 MHz clock domain; all users reference names with rfsr_pkg::.
 */
package rfsr_pkg;

    // ==========================================================
    // command codes (register offsets)
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] OFF_SUMMARY_BYTE = 8'h78;
    localparam logic [7:0] OFF_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] OFF_OUTPUT_VOLTAGE_SUMMARY_STATUS = 8'h7a;

    // ==========================================================
    // summary byte / word / output-voltage status field positions
    localparam int SB_NVM_BUSY = 7;
    localparam int SB_RAIL_OFF = 6;
    localparam int SB_OV = 5;
    localparam int SB_OC = 4;
    localparam int SB_VIN_UV = 3;
    localparam int SB_TEMP = 2;
    localparam int SB_COMM = 1;
    localparam int SB_IIN_WARN = 0;
    localparam int SW_OUTPUT_VOLTAGE_SUMMARY = 15;
    localparam int SW_OUTPUT_CURRENT_POWER_SUMMARY = 14;
    localparam int SW_INPUT = 13;
    localparam int SW_SYS_ANA = 12;
    localparam int SW_READY = 11;
    localparam int SW_SYS_DIG = 10;
    localparam int SW_WDOG = 8;
    localparam int VS_OV = 7;
    localparam int VS_UV = 4;
    localparam int VS_LIMIT = 3;
    localparam int VS_FLOAT = 1;

    // ==========================================================
    // sticky flag indices
    localparam int FL_OV = 0;
    localparam int FL_OC = 1;
    localparam int FL_VIN_UV = 2;
    localparam int FL_TEMP = 3;
    localparam int FL_COMM = 4;
    localparam int FL_IIN_WARN = 5;
    localparam int FL_OUTPUT_VOLTAGE_SUMMARY_SUM = 6;
    localparam int FL_IOUT_SUM = 7;
    localparam int FL_INPUT_SUM = 8;
    localparam int FL_SYS_ANA = 9;
    localparam int FL_SYS_DIG = 10;
    localparam int FL_WDOG = 11;
    localparam int FL_UV = 12;
    localparam int FL_LIMIT = 13;
    localparam int FL_FLOAT = 14;
    localparam int FL_COUNT = 15;

    // ==========================================================
    // reset values and timing
    localparam logic [15:0] RD_DATA_RST = 16'h0000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int PG_DELAY_LSB_NS = 2000;
    localparam int PG_DELAY_LSB_CYC = PG_DELAY_LSB_NS / CLK_PERIOD_NS;
    localparam int WDOG_LIMIT_CYC = 1024;
    localparam int VID_W = 9;
    localparam int CODE_W = 12;

    typedef enum logic [1:0] {
        RFSR_RDY_IDLE = 2'b00,
        RFSR_RDY_WAIT = 2'b01,
        RFSR_RDY_GOOD = 2'b10
    } rfsr_rdy_e;

    // protection and warning events from rail logic (same clock)
    typedef struct packed {
        logic ovp_trip;
        logic ocp_trip;
        logic uvp_trip;
        logic output_voltage_summary_ov_warn;
        logic output_voltage_summary_uv_warn;
        logic iout_warn;
        logic pout_fault;
        logic pout_warn;
        logic input_undervoltage_flag;
        logic vin_ov_fault;
        logic iin_oc_fault;
        logic input_overcurrent_warning;
        logic pin_warn;
        logic ot_warn;
        logic ot_fault;
        logic comm_fault;
        logic sys_ana_fault;
        logic sys_dig_fault;
        logic line_float;
        logic prot_off;
    } rfsr_evt_s;

    // ready configuration from the power-good registers
    typedef struct packed {
        logic pol_mode;
        logic [6:0] pg_delay;
        logic [VID_W-1:0] pg_on;
        logic [VID_W-1:0] pg_off;
    } rfsr_rdy_cfg_s;

endpackage : rfsr_pkg

// ### hdl/rfsr_sticky.sv
/*
 * rfsr_sticky: bank of latched status flags, one per entry.
 * Assumes set and clear come from the same clock domain; set wins over clear.
 */
`timescale 1ns/100ps

module rfsr_sticky #(
    parameter int N = 8
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic [N-1:0] set, // event per flag
    input wire logic clear, // clear-faults pulse
    output logic [N-1:0] flags // latched flags
);

    // ==========================================================
    // per-flag latch
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flags[i] <= 1'b0;
                end else begin
                    flags[i] <= set[i] | (flags[i] & ~clear);
                end
            end
        end
    endgenerate

endmodule // rfsr_sticky

// ### hdl/rfsr_ready.sv
/*
 * rfsr_ready: rail ready (power-good) tracker for both ready modes.
 * Assumes threshold and delay settings are static on the same clock.
 */
`timescale 1ns/100ps

module rfsr_ready (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronised reset, active low
    input wire rfsr_pkg::rfsr_rdy_cfg_s cfg, // mode, thresholds, delay
    input wire logic [rfsr_pkg::VID_W-1:0] output_voltage_summary_code, // present output code
    input wire logic boot_reached, // output at boot-up voltage
    input wire logic enabled, // rail output is on
    input wire logic fault, // OV, OC or UV trip, line float or protection off
    output logic ready // rail ready flag
);

    rfsr_pkg::rfsr_rdy_e state_reg;
    rfsr_pkg::rfsr_rdy_e state_next;
    logic [13:0] cnt_reg;
    logic [13:0] delay_cyc;
    logic below_off;

    assign delay_cyc = 14'(cfg.pg_delay * rfsr_pkg::PG_DELAY_LSB_CYC);
    assign below_off = output_voltage_summary_code < cfg.pg_off;

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rfsr_pkg::RFSR_RDY_IDLE: begin
                if (!cfg.pol_mode) begin
                    if (boot_reached && enabled && !fault) state_next = rfsr_pkg::RFSR_RDY_GOOD;
                end else if (output_voltage_summary_code > cfg.pg_on && !fault) begin
                    state_next = rfsr_pkg::RFSR_RDY_WAIT;
                end
            end
            rfsr_pkg::RFSR_RDY_WAIT: begin
                if (fault || below_off || !cfg.pol_mode) begin
                    state_next = rfsr_pkg::RFSR_RDY_IDLE;
                end else if (cnt_reg >= delay_cyc) begin
                    state_next = rfsr_pkg::RFSR_RDY_GOOD;
                end
            end
            rfsr_pkg::RFSR_RDY_GOOD: begin
                if (!cfg.pol_mode) begin
                    if (!enabled || fault) state_next = rfsr_pkg::RFSR_RDY_IDLE;
                end else if (fault || below_off) begin
                    state_next = rfsr_pkg::RFSR_RDY_IDLE;
                end
            end
            default: state_next = rfsr_pkg::RFSR_RDY_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= rfsr_pkg::RFSR_RDY_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // delay counter, runs only while waiting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (state_reg == rfsr_pkg::RFSR_RDY_WAIT) begin
            cnt_reg <= cnt_reg + 14'd1;
        end else begin
            cnt_reg <= '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b0;
        end else begin
            ready <= (state_next == rfsr_pkg::RFSR_RDY_GOOD);
        end
    end

endmodule // rfsr_ready

// ### verif/rfsr_host_model.sv
/*
 * rfsr_host_model: host side of the status bank command port.
 * Assumes one free-running clk; answers come on the taking edge and are read 1 ns after it.
 */
`timescale 1ns/100ps

module rfsr_host_model (
    input wire logic clk, // system clock
    output logic cmd_valid, // command strobe
    output logic [7:0] cmd_code, // command code
    input wire logic rd_valid, // read answer pulse
    input wire logic [15:0] rd_data, // read data
    input wire logic rd_unsup // refused code pulse
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
    end

    // ==========================================================
    // one command; code line scrambled once released
    task automatic host_cmd(input logic [7:0] code, output logic [15:0] data,
            output logic [1:0] ans);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        #1;
        data = rd_data;
        ans = {rd_unsup, rd_valid};
    endtask

    task automatic host_clear(output logic [1:0] ans);
        logic [15:0] d;
        host_cmd(rfsr_pkg::CMD_CLEAR_FAULTS, d, ans);
    endtask
endmodule // rfsr_host_model

// ### verif/test_rail_fault_status_registers.sv
/*
 * test_rail_fault_status_registers: self-checking bench for rfsr_top.
 * Assumes rfsr_host_model on the command port; 40 MHz clock.
 */
`timescale 1ns/100ps

module test_rail_fault_status_registers;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    rfsr_pkg::rfsr_evt_s evt = '0;
    logic nvm_busy_flag = 1'b0;
    logic rail_en_pin = 1'b1;
    logic [rfsr_pkg::VID_W-1:0] vid_code = 9'h080;
    logic [rfsr_pkg::CODE_W-1:0] code_max = 12'h100;
    logic [rfsr_pkg::CODE_W-1:0] code_min = 12'h010;
    logic [rfsr_pkg::VID_W-1:0] output_voltage_summary_code = 9'h000;
    logic boot_reached = 1'b0;
    rfsr_pkg::rfsr_rdy_cfg_s rdy_cfg = '0;
    logic mon_start = 1'b0;
    logic mon_done = 1'b0;
    wire logic cmd_valid, rd_valid, rd_unsup, mon_sm_reset, rail_shutdown;
    wire logic regulator_ready_output;
    wire logic [7:0] cmd_code;
    wire logic [15:0] rd_data;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int n;
    logic [15:0] d;
    logic [1:0] a;
    // {byte, word high, output_voltage_summary status} per event bit
    logic [23:0] tab [1:19] = '{24'h400002, 24'h000400, 24'h001000, 24'h020000, 24'h040000,
        24'h040000, 24'h002000, 24'h012000, 24'h002000, 24'h002000, 24'h082000, 24'h004000,
        24'h004000, 24'h004000, 24'h008000, 24'h008000, 24'h008010, 24'h104000, 24'h208080};

    rfsr_top rfsr_top_i (.clk, .reset_n, .cmd_valid, .cmd_code, .rd_valid, .rd_data, .rd_unsup,
        .evt, .nvm_busy_flag, .rail_en_pin, .vid_code, .code_max, .code_min, .output_voltage_summary_code,
        .boot_reached, .rdy_cfg, .mon_start, .mon_done, .mon_sm_reset, .rail_shutdown,
        .regulator_ready_output);
    rfsr_host_model rfsr_host_model_i (.clk, .cmd_valid, .cmd_code, .rd_valid, .rd_data,
        .rd_unsup);

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            print_verdict();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        rfsr_host_model_i.host_cmd(c, d, a);
        chk({14'h0, a}, 16'h0001);
        chk(d, exp);
    endtask
    task automatic clr();
        rfsr_host_model_i.host_clear(a);
        chk({14'h0, a}, 16'h0000);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_live();
        @(posedge clk) {nvm_busy_flag, rail_en_pin} <= 2'b10;
        idle(4);
        rd(8'h78, 16'h00c0);
        rd(8'h79, 16'h00c0);
        @(posedge clk) {nvm_busy_flag, rail_en_pin, vid_code} <= {2'b01, 9'h000};
        idle(4);
        rd(8'h78, 16'h0040);
        @(posedge clk) vid_code <= 9'h080;
        rd(8'h78, 16'h0000);
        rd(8'h7a, 16'h0008);
        clr();
        @(posedge clk) evt.prot_off <= 1'b1;
        rd(8'h78, 16'h0040);
        @(posedge clk) evt.prot_off <= 1'b0;
        rfsr_host_model_i.host_cmd(8'h7b, d, a);
        chk({14'h0, a}, 16'h0002);
    endtask
    task automatic t_sticky();
        for (int i = 1; i < 20; i++) begin
            @(posedge clk) evt <= rfsr_pkg::rfsr_evt_s'(20'h1 << i);
            @(posedge clk) evt <= '0;
            idle(3);
            rd(8'h78, {8'h0, tab[i][23:16]});
            rd(8'h79, {tab[i][15:8], tab[i][23:16]});
            rd(8'h7a, {8'h0, tab[i][7:0]});
            chk({15'h0, rail_shutdown}, {15'h0, i == 1});
            clr();
            rd(8'h79, 16'h0000);
            rd(8'h7a, 16'h0000);
        end
    endtask
    task automatic t_limit();
        foreach (tab[j]) if (j < 3) begin
            @(posedge clk) vid_code <= (j == 1) ? 9'h101 : 9'h00f;
            idle(3);
            @(posedge clk) vid_code <= 9'h080;
            rd(8'h7a, 16'h0008);
            clr();
            rd(8'h7a, 16'h0000);
        end
    endtask
    task automatic t_wdog();
        @(posedge clk) mon_start <= 1'b1;
        @(posedge clk) mon_start <= 1'b0;
        n = 0;
        while (mon_sm_reset !== 1'b1 && n < 1100) begin
            @(posedge clk);
            n++;
        end
        chk(16'(n inside {[1020:1028]}), 16'h0001);
        rd(8'h79, 16'h0100);
        clr();
        @(posedge clk) mon_start <= 1'b1;
        @(posedge clk) mon_start <= 1'b0;
        idle(10);
        @(posedge clk) mon_done <= 1'b1;
        @(posedge clk) mon_done <= 1'b0;
        idle(1100);
        rd(8'h79, 16'h0000);
    endtask
    task automatic t_ready();
        @(posedge clk) boot_reached <= 1'b1;
        idle(4);
        rd(8'h79, 16'h0800);
        @(posedge clk) rail_en_pin <= 1'b0;
        idle(6);
        rd(8'h79, 16'h0040);
        @(posedge clk) {rail_en_pin, boot_reached} <= 2'b10;
        rdy_cfg <= '{pol_mode: 1'b1, pg_delay: 7'h02, pg_on: 9'h080, pg_off: 9'h070};
        output_voltage_summary_code <= 9'h090;
        n = 0;
        while (regulator_ready_output !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk(16'(n inside {[158:166]}), 16'h0001);
        @(posedge clk) evt.ovp_trip <= 1'b1;
        @(posedge clk) evt.ovp_trip <= 1'b0;
        idle(3);
        chk({15'h0, regulator_ready_output}, 16'h0000);
        clr();
        idle(200);
        chk({15'h0, regulator_ready_output}, 16'h0001);
        @(posedge clk) output_voltage_summary_code <= 9'h060;
        idle(4);
        rd(8'h79, 16'h0000);
    endtask

    initial begin
        idle(5);
        reset_n <= 1'b1;
        idle(4);
        t_live();
        t_sticky();
        t_limit();
        t_wdog();
        t_ready();
        print_verdict();
    end
endmodule // test_rail_fault_status_registers
